// ---- pkg/cfer_pkg.sv ----
// Purpose: Shared constants and carriers for the charger fault event responder
// Assumes: 25 MHz clock, plain register port with 16-bit data
// Notes: Flag and mask registers share one bit layout; the status register holds the conditions in reverse order
package cfer_pkg;
    // Register port geometry
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam int FLAG_W = 12;
    // Register offsets
    localparam logic [ADDR_W-1:0] REG_FLAGS = 4'h0;
    localparam logic [ADDR_W-1:0] REG_MASK = 4'h1;
    localparam logic [ADDR_W-1:0] REG_CTRL = 4'h2;
    localparam logic [ADDR_W-1:0] REG_STAT = 4'h3;
    // Flag bit positions
    localparam int F_THERM = 0;
    localparam int F_VALID = 1;
    localparam int F_BATOC = 2;
    localparam int F_COLD = 3;
    localparam int F_COOL = 4;
    localparam int F_WARM = 5;
    localparam int F_HOT = 6;
    localparam int F_WDOG = 7;
    localparam int F_SAFE = 8;
    localparam int F_BTN1 = 9;
    localparam int F_BTN2 = 10;
    localparam int F_BTNW = 11;
    // Control fields
    localparam int CTRL_DOUBLE = 0;
    localparam int CTRL_RAIL_LSB = 1;
    localparam logic [1:0] RAIL_FROM_INPUT = 2'h0;
    localparam logic [DATA_W-1:0] CTRL_RESET = 16'h0001;
    localparam logic [FLAG_W-1:0] MASK_RESET = 12'h000;
    // Temperature fault pulse on the interrupt line
    localparam int CLK_HZ = 25_000_000;
    localparam int PULSE_NS = 128_000;
    localparam int PULSE_CYC = (PULSE_NS / 1000) * (CLK_HZ / 1_000_000);
    // Condition inputs sampled every clock
    typedef struct packed {
        logic thermal_foldback;
        logic input_valid_status;
        logic bat_overcurrent;
        logic temp_cold;
        logic temp_cool;
        logic temp_warm;
        logic temp_hot;
        logic watchdog_expired;
    } cfer_cond_t;
    // Charger response outputs
    typedef struct packed {
        logic charge_on;
        logic current_reduced;
        logic vreg_reduced;
        logic rail_from_input;
        logic bat_disconnect;
    } cfer_resp_t;
endpackage

// ---- hw/cfer_top.sv ----
// Purpose: Fault and flag event logic with charger response and interrupt
// Assumes: Condition inputs synchronous to clk; register read data one cycle late
// Notes: Flags clear on read of the flag register or by writing ones to it
`timescale 1ns/100ps
`default_nettype none
module cfer_top import cfer_pkg::*; #(
    parameter int SAFETY_CYC = 1_000_000,
    parameter int WAKE1_CYC = 5_000,
    parameter int WAKE2_CYC = 25_000,
    parameter int WARN_CYC = 50_000,
    parameter int TMR_W = 32
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [DATA_W-1:0] rdata,
    input wire cfer_cond_t cond,
    input wire logic charge_enable_pin,
    input wire logic push_button_input_n,
    output cfer_resp_t resp,
    output logic irq
);
    // Latched flags, mask and control
    logic [FLAG_W-1:0] flags;
    logic [FLAG_W-1:0] next_flags;
    logic [FLAG_W-1:0] mask;
    logic [DATA_W-1:0] ctrl;
    // Previous-cycle copies for edge detection
    cfer_cond_t cond_prev;
    logic [2:0] hold_prev;
    logic ce_prev;
    // Safety timer state
    logic [TMR_W-1:0] timer;
    logic half;
    logic safety_fault;
    // Button hold counter and thresholds reached
    logic [TMR_W-1:0] btn_cnt;
    logic [2:0] hold;
    // Temperature pulse counter
    logic [11:0] pulse_cnt;
    // Derived events and controls
    logic [FLAG_W-1:0] set_ev;
    logic [FLAG_W-1:0] clr_ev;
    logic expire;
    logic run;
    logic slow;
    logic safe_cleared;
    logic temp_ev;
    logic [1:0] rail_mode;
    cfer_resp_t next_resp;

    // Rail mode field of the control register
    assign rail_mode = ctrl[CTRL_RAIL_LSB +: 2];
    // Reached thresholds while the button is held low
    assign hold[0] = btn_cnt >= TMR_W'(WAKE1_CYC);
    assign hold[1] = btn_cnt >= TMR_W'(WAKE2_CYC);
    assign hold[2] = btn_cnt >= TMR_W'(WARN_CYC);

    // Edge events, one per transition
    always_comb begin
        set_ev = '0;
        set_ev[F_THERM] = cond.thermal_foldback && !cond_prev.thermal_foldback;
        set_ev[F_VALID] = cond.input_valid_status != cond_prev.input_valid_status;
        set_ev[F_BATOC] = cond.bat_overcurrent && !cond_prev.bat_overcurrent;
        set_ev[F_COLD] = cond.temp_cold && !cond_prev.temp_cold;
        set_ev[F_COOL] = cond.temp_cool && !cond_prev.temp_cool;
        set_ev[F_WARM] = cond.temp_warm && !cond_prev.temp_warm;
        set_ev[F_HOT] = cond.temp_hot && !cond_prev.temp_hot;
        set_ev[F_WDOG] = cond.watchdog_expired && !cond_prev.watchdog_expired;
        set_ev[F_SAFE] = expire;
        set_ev[F_BTN1] = hold[0] && !hold_prev[0];
        set_ev[F_BTN2] = hold[1] && !hold_prev[1];
        set_ev[F_BTNW] = hold[2] && !hold_prev[2];
    end

    // Read of the flag register or write-one clears; a new event wins
    always_comb begin
        clr_ev = '0;
        if (rd && addr == REG_FLAGS) begin
            clr_ev = '1;
        end else if (wr && addr == REG_FLAGS) begin
            clr_ev = wdata[FLAG_W-1:0];
        end
        next_flags = (flags & ~clr_ev) | set_ev;
    end
    assign safe_cleared = flags[F_SAFE] && !next_flags[F_SAFE];

    // Flag storage
    always_ff @(posedge clk) begin
        if (rst) begin
            flags <= '0;
        end else begin
            flags <= next_flags;
        end
    end

    // Edge history
    always_ff @(posedge clk) begin
        if (rst) begin
            cond_prev <= '0;
            hold_prev <= '0;
        end else begin
            cond_prev <= cond;
            hold_prev <= hold;
        end
    end

    // Enable pin history has no reset: it follows the pin during reset,
    // so release never shows a false toggle
    always_ff @(posedge clk) begin
        ce_prev <= charge_enable_pin;
    end

    // Mask and control registers
    always_ff @(posedge clk) begin
        if (rst) begin
            mask <= MASK_RESET;
            ctrl <= CTRL_RESET;
        end else if (wr && addr == REG_MASK) begin
            mask <= wdata[FLAG_W-1:0];
        end else if (wr && addr == REG_CTRL) begin
            ctrl <= wdata & 16'h0007;
        end
    end

    // Read data, one cycle after the strobe; unmapped reads zero
    // Zero outside the answer cycle keeps stale data off the bus
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata <= '0;
        end else if (rd) begin
            unique case (addr)
                REG_FLAGS: rdata <= {4'h0, flags};
                REG_MASK: rdata <= {4'h0, mask};
                REG_CTRL: rdata <= ctrl;
                REG_STAT: rdata <= {7'h00, safety_fault, cond};
                default: rdata <= '0;
            endcase
        end else begin
            rdata <= '0;
        end
    end

    // Safety timer stops on temperature pause and charge stop
    assign slow = ctrl[CTRL_DOUBLE] && (cond.thermal_foldback || cond.temp_cool);
    assign run = resp.charge_on && !cond.temp_cold && !cond.temp_hot && (!slow || half);
    assign expire = run && timer == TMR_W'(SAFETY_CYC - 1);

    // Timer count; doubled duration means one step every second cycle
    // A cut input or a cleared expiry flag always wins over counting
    always_ff @(posedge clk) begin
        if (rst) begin
            timer <= '0;
            half <= 1'b0;
        end else if (!cond.input_valid_status || safe_cleared) begin
            timer <= '0;
            half <= 1'b0;
        end else begin
            half <= !half;
            if (expire) begin
                timer <= '0;
            end else if (run) begin
                timer <= timer + 1'b1;
            end
        end
    end

    // Expiry latch holds charging off until input or enable pin toggles
    always_ff @(posedge clk) begin
        if (rst) begin
            safety_fault <= 1'b0;
        end else if (expire) begin
            safety_fault <= 1'b1;
        end else if (set_ev[F_VALID] || charge_enable_pin != ce_prev) begin
            safety_fault <= 1'b0;
        end
    end

    // Button hold counter, saturating while low
    // Stops at the longest threshold so the count can never wrap
    always_ff @(posedge clk) begin
        if (rst || push_button_input_n) begin
            btn_cnt <= '0;
        end else if (!hold[2]) begin
            btn_cnt <= btn_cnt + 1'b1;
        end
    end

    // Charger response; watchdog expiry deliberately leaves charging alone
    // Cut input, overcurrent, hot, cold or expiry each stop charging
    always_comb begin
        next_resp.charge_on = cond.input_valid_status && !cond.bat_overcurrent
            && !cond.temp_cold && !cond.temp_hot && !safety_fault;
        next_resp.current_reduced = cond.thermal_foldback || cond.temp_cool;
        next_resp.vreg_reduced = cond.temp_warm;
        next_resp.rail_from_input = cond.input_valid_status && rail_mode == RAIL_FROM_INPUT;
        next_resp.bat_disconnect = cond.bat_overcurrent;
    end

    // Registered response outputs
    always_ff @(posedge clk) begin
        if (rst) begin
            resp <= '0;
        end else begin
            resp <= next_resp;
        end
    end

    // Temperature fault pulse; a new zone entry restarts it
    // Loaded one short: the line trails the count by one edge
    assign temp_ev = |set_ev[F_HOT:F_COLD];
    always_ff @(posedge clk) begin
        if (rst) begin
            pulse_cnt <= '0;
        end else if (temp_ev) begin
            pulse_cnt <= 12'(PULSE_CYC - 1);
        end else if (pulse_cnt != 12'h000) begin
            pulse_cnt <= pulse_cnt - 1'b1;
        end
    end

    // Level from unmasked flags, or the fault pulse
    // Built from next_flags so the line moves in step with the flags
    always_ff @(posedge clk) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(next_flags & mask) || temp_ev || pulse_cnt != 12'h000;
        end
    end

    // Checks
    // Rising foldback latches its flag
    therm_flag_a: assert property (@(posedge clk) disable iff (rst)
        $rose(cond.thermal_foldback) |=> flags[F_THERM])
        else $error("thermal flag not set");

    // Falling input validity is flagged too
    valid_edge_a: assert property (@(posedge clk) disable iff (rst)
        $fell(cond.input_valid_status) |=> flags[F_VALID])
        else $error("input valid fall not flagged");

    // Invalid input stops charging and clears the safety count
    valid_low_a: assert property (@(posedge clk) disable iff (rst)
        !cond.input_valid_status |=> !resp.charge_on && timer == '0)
        else $error("charging with input invalid");

    // Any other rail mode keeps the rail off the input
    rail_mode_a: assert property (@(posedge clk) disable iff (rst)
        rail_mode != RAIL_FROM_INPUT |=> !resp.rail_from_input)
        else $error("rail from input in other mode");

    // Overcurrent stops charging and cuts the battery off the rail
    batoc_resp_a: assert property (@(posedge clk) disable iff (rst)
        cond.bat_overcurrent |=> !resp.charge_on && resp.bat_disconnect)
        else $error("overcurrent response wrong");

    // Hot or cold freezes the count and pauses charging
    temp_pause_a: assert property (@(posedge clk) disable iff (rst)
        (cond.temp_cold || cond.temp_hot) && cond.input_valid_status && !safe_cleared
        |=> $stable(timer) && !resp.charge_on)
        else $error("hot or cold did not pause");

    // Cool zone flags and lowers the current
    cool_current_a: assert property (@(posedge clk) disable iff (rst)
        $rose(cond.temp_cool) |=> flags[F_COOL] && resp.current_reduced)
        else $error("cool response wrong");

    // Warm zone lowers the regulation voltage
    warm_vreg_a: assert property (@(posedge clk) disable iff (rst)
        cond.temp_warm |=> resp.vreg_reduced)
        else $error("warm regulation not lowered");

    // Watchdog expiry flags but leaves charging alone
    wdog_keep_a: assert property (@(posedge clk) disable iff (rst)
        $rose(cond.watchdog_expired) && next_resp.charge_on |=> flags[F_WDOG] && resp.charge_on)
        else $error("watchdog handling wrong");

    // Expiry flags, then charging drops an edge later
    safety_off_a: assert property (@(posedge clk) disable iff (rst)
        expire |=> flags[F_SAFE] ##1 !resp.charge_on)
        else $error("safety expiry left charging on");

    // Clearing the expiry flag restarts the count
    timer_restart_a: assert property (@(posedge clk) disable iff (rst)
        safe_cleared |=> timer == '0)
        else $error("timer not restarted");

    // First hold time flags one edge after the count reaches it
    button_hold_a: assert property (@(posedge clk) disable iff (rst)
        !push_button_input_n && btn_cnt == TMR_W'(WAKE1_CYC - 1) |=> ##1 flags[F_BTN1])
        else $error("first hold not flagged");

    // Zone entry raises the line at once
    temp_pulse_a: assert property (@(posedge clk) disable iff (rst)
        temp_ev |=> irq [*8])
        else $error("temperature pulse missing");

    // The watchdog flag stays put without a register access
    flag_hold_a: assert property (@(posedge clk) disable iff (rst)
        flags[F_WDOG] && !rd && !wr |=> flags[F_WDOG])
        else $error("flag dropped without read");

    // Foldback lowers the charge current
    thermal_current_a: assert property (@(posedge clk) disable iff (rst)
        cond.thermal_foldback |=> resp.current_reduced)
        else $error("foldback current not reduced");

    // Valid input in the default mode feeds the rail from the input
    rail_feed_a: assert property (@(posedge clk) disable iff (rst)
        cond.input_valid_status && rail_mode == RAIL_FROM_INPUT |=> resp.rail_from_input)
        else $error("rail not fed from input");

    // The expiry latch keeps charging off
    latch_block_a: assert property (@(posedge clk) disable iff (rst)
        safety_fault |=> !resp.charge_on)
        else $error("charging during expiry latch");

    // Reset warning hold flags like the first hold
    warn_hold_a: assert property (@(posedge clk) disable iff (rst)
        !push_button_input_n && btn_cnt == TMR_W'(WARN_CYC - 1) |=> ##1 flags[F_BTNW])
        else $error("reset warning not flagged");

    // A flag read with no new event leaves nothing set
    read_clear_a: assert property (@(posedge clk) disable iff (rst)
        rd && addr == REG_FLAGS && set_ev == '0 |=> flags == '0)
        else $error("flag read did not clear");
endmodule
`default_nettype wire

// ---- tb/cfer_host.sv ----
// Purpose: Host processor model that reaches the flag, mask and control registers
// Assumes: Plain register port, read data one cycle after the read strobe
// Notes: Signals are set idle by blocking assignment at time zero, then change only by non-blocking assignment just after a rising edge
`timescale 1ns/100ps
`default_nettype none
module cfer_host import cfer_pkg::*; (
    input wire logic clk,
    input wire logic [DATA_W-1:0] rdata,
    input wire logic irq,
    output logic [ADDR_W-1:0] addr,
    output logic [DATA_W-1:0] wdata,
    output logic wr,
    output logic rd
);
    // Bus idle from time zero
    initial begin
        addr = '0;
        wdata = '0;
        wr = 1'b0;
        rd = 1'b0;
    end
    // One-cycle write strobe beside address and data
    task automatic write_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // Read acknowledges flags; data taken in the cycle after the strobe only
    task automatic read_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
endmodule
`default_nettype wire

// ---- tb/charger_fault_event_responder_bench.sv ----
// Purpose: Self-checking bench for the charger fault event responder
// Assumes: Short safety and button counts set by parameter
// Notes: The safety, edge and hot scenarios refresh input validity first so the safety timer starts at zero
`timescale 1ns/100ps
`default_nettype none
module charger_fault_event_responder_bench import cfer_pkg::*;;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata, rdata, rv;
    logic wr, rd, irq;
    cfer_cond_t cond = '0;
    logic charge_enable_pin = 1'b1;
    logic push_button_input_n = 1'b1; // Button released
    cfer_resp_t resp;
    int err_count = 0;
    int tests_run = 0;
    // Condition bit, flag bit and response for each rising-only event
    int ci[7] = '{7, 5, 4, 3, 2, 1, 0};
    int fb[7] = '{0, 2, 3, 4, 5, 6, 7};
    logic [4:0] er[7] = '{5'h1a, 5'h03, 5'h02, 5'h1a, 5'h16, 5'h02, 5'h12};
    // Free-running 25 MHz clock
    always #20 clk = ~clk;
    cfer_top #(.SAFETY_CYC(200), .WAKE1_CYC(4), .WAKE2_CYC(8), .WARN_CYC(12), .TMR_W(32)) DUT (
        .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .cond(cond), .charge_enable_pin(charge_enable_pin),
        .push_button_input_n(push_button_input_n), .resp(resp), .irq(irq));
    cfer_host host (.clk(clk), .rdata(rdata), .irq(irq), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd));
    // Verdict and end of run
    task automatic summarize();
        if (err_count == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Compare and count
    task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Wait whole cycles, then settle past the edge
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        host.read_reg(a, rv);
        chk(rv, exp);
    endtask
    // Input drop restarts the safety timer; the read discards the change flags
    task automatic refresh();
        @(posedge clk) cond.input_valid_status <= 1'b0;
        cyc(2);
        @(posedge clk) cond.input_valid_status <= 1'b1;
        cyc(3);
        host.read_reg(REG_FLAGS, rv);
    endtask
    // Reset values, unmapped place, read-only status
    task automatic t_reset();
        chk({11'h0, resp}, 16'h0000);
        rdchk(REG_MASK, 16'h0000);
        rdchk(REG_CTRL, 16'h0001);
        rdchk(4'h9, 16'h0000);
        host.write_reg(REG_STAT, 16'hffff);
        rdchk(REG_STAT, 16'h0000);
        rdchk(REG_FLAGS, 16'h0000);
    endtask
    // Input validity: both edges flagged, rail mode selects the feed
    task automatic t_valid();
        @(posedge clk) cond.input_valid_status <= 1'b1;
        cyc(3);
        rdchk(REG_FLAGS, 16'h0002);
        chk({11'h0, resp}, 16'h0012);
        host.write_reg(REG_CTRL, 16'h0003);
        cyc(2);
        chk({11'h0, resp}, 16'h0010);
        host.write_reg(REG_CTRL, 16'h0001);
        @(posedge clk) cond.input_valid_status <= 1'b0;
        cyc(3);
        rdchk(REG_FLAGS, 16'h0002);
        chk({11'h0, resp}, 16'h0000);
        refresh();
    endtask
    // Masked interrupt level, cleared by writing a one
    task automatic t_mask();
        host.write_reg(REG_MASK, 16'h0080);
        @(posedge clk) cond.watchdog_expired <= 1'b1;
        cyc(3);
        chk({15'h0, irq}, 16'h0001);
        chk({15'h0, resp.charge_on}, 16'h0001);
        host.write_reg(REG_FLAGS, 16'h0080);
        cyc(2);
        chk({15'h0, irq}, 16'h0000);
        host.write_reg(REG_MASK, 16'h0000);
        @(posedge clk) cond.watchdog_expired <= 1'b0;
        refresh();
    endtask
    // Expiry latch, toggle release, restart after clear, doubled duration
    task automatic t_safety();
        refresh();
        cyc(150);
        rdchk(REG_STAT, 16'h0040);
        cyc(80);
        rdchk(REG_FLAGS, 16'h0100);
        chk({15'h0, resp.charge_on}, 16'h0000);
        @(posedge clk) charge_enable_pin <= 1'b0;
        cyc(2);
        @(posedge clk) charge_enable_pin <= 1'b1;
        cyc(3);
        chk({15'h0, resp.charge_on}, 16'h0001);
        cyc(150);
        rdchk(REG_FLAGS, 16'h0000);
        // Second expiry: toggle resumes charging, then the flag clear restarts the count
        cyc(50);
        @(posedge clk) charge_enable_pin <= 1'b0;
        @(posedge clk) charge_enable_pin <= 1'b1;
        cyc(100);
        rdchk(REG_FLAGS, 16'h0100);
        cyc(150);
        rdchk(REG_FLAGS, 16'h0000);
        refresh();
        @(posedge clk) cond.thermal_foldback <= 1'b1;
        cyc(300);
        rdchk(REG_FLAGS, 16'h0001);
        @(posedge clk) cond.thermal_foldback <= 1'b0;
        refresh();
    endtask
    // Button hold times: short hold gives one flag, long hold gives three
    task automatic t_button();
        @(posedge clk) push_button_input_n <= 1'b0;
        cyc(6);
        @(posedge clk) push_button_input_n <= 1'b1;
        cyc(3);
        rdchk(REG_FLAGS, 16'h0200);
        @(posedge clk) push_button_input_n <= 1'b0;
        cyc(16);
        @(posedge clk) push_button_input_n <= 1'b1;
        cyc(3);
        rdchk(REG_FLAGS, 16'h0e00);
    endtask
    // Rising-only events: one flag per transition, response follows the level
    task automatic t_edges();
        for (int i = 0; i < 7; i++) begin
            refresh();
            @(posedge clk) cond[ci[i]] <= 1'b1;
            cyc(2);
            chk({11'h0, resp}, {11'h0, er[i]});
            rdchk(REG_FLAGS, 16'h0001 << fb[i]);
            rdchk(REG_FLAGS, 16'h0000);
            @(posedge clk) cond[ci[i]] <= 1'b0;
            cyc(2);
            rdchk(REG_FLAGS, 16'h0000);
        end
    endtask
    // Hot zone: pulse beats the mask, flag held and timer frozen meanwhile
    task automatic t_hot();
        refresh();
        @(posedge clk) cond.temp_hot <= 1'b1;
        cyc(2);
        chk({15'h0, irq}, 16'h0001);
        cyc(3198);
        chk({15'h0, irq}, 16'h0001);
        cyc(1);
        chk({15'h0, irq}, 16'h0000);
        rdchk(REG_FLAGS, 16'h0040);
        rdchk(REG_FLAGS, 16'h0000);
        @(posedge clk) cond.temp_hot <= 1'b0;
    endtask
    // Hang guard
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        summarize();
    end
    // Main sequence
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        cyc(1);
        t_reset();
        t_valid();
        t_mask();
        t_safety();
        t_button();
        t_edges();
        t_hot();
        summarize();
    end
endmodule
`default_nettype wire
